/* File: hdl/trh_cfg.svh */
// Functional notes
// [RQ1] Positive pulse mode drives the pin high about 250 ms on activation.
// [RQ2] Negative pulse mode drives the pin low about 250 ms on activation.
// [RQ3] Each unit pass output is active when that unit's verdict is pass.
// [RQ4] At completion the overall pass output is active only if all units passed.
// [RQ5] At completion the overall fail output is active when all units failed.
// [RQ6] After test start, wait is active whenever high voltage is absent.
// [RQ7] Ready is active while the system is idle, not testing.
// [RQ8] Test-in-progress is active from start until the whole file ends.
// [RQ9] High-voltage output is active while high voltage is delivered.
// [RQ10] Fault output is active whenever a malfunction is detected.
// [RQ11] Positive-level mode shows an active output as a high pin.
// [RQ12] Negative-level mode shows an active output as a low pin.
// [RQ13] Step granularity presents results per step; file granularity at file end.
// [RQ14] Each output has its own signal type and its own pulse counter.
// [RQ15] The spare output always stays at its inactive level.
`ifndef TRH_CFG_SVH
`define TRH_CFG_SVH
`define TRH_ADDR_W 8
`define TRH_DATA_W 32
`define TRH_OFS_CTRL 8'h00
`define TRH_OFS_MODE 8'h04
`define TRH_OFS_STAT 8'h08
`define TRH_OFS_IRQ_STAT 8'h0c
`define TRH_OFS_IRQ_MASK 8'h10
`define TRH_RST_CTRL 1'h0
`define TRH_RST_MODE 32'h0000_0000
`define TRH_RST_MASK 4'h0
`define TRH_NUM_PINS 16
`define TRH_NUM_UNITS 8
`define TRH_PIN_PASS 8
`define TRH_PIN_FAIL 9
`define TRH_PIN_SPARE 10
`define TRH_PIN_WAIT 11
`define TRH_PIN_READY 12
`define TRH_PIN_TEST 13
`define TRH_PIN_HV 14
`define TRH_PIN_FAULT 15
`define TRH_EV_START 0
`define TRH_EV_FILE_END 1
`define TRH_EV_FAULT 2
`define TRH_EV_STEP_END 3
`define TRH_NUM_EV 4
`define TRH_PULSE_MS 250
`define TRH_CLK_KHZ 200000
`define TRH_PULSE_CYC (`TRH_PULSE_MS * `TRH_CLK_KHZ)
`endif

/* File: hdl/trh_pkg.sv */
package trh_pkg;
  typedef enum logic [1:0]
  {
    active_high_level = 2'h0,
    active_low_level = 2'h1,
    positive_pulse = 2'h2,
    negative_pulse = 2'h3
  } trh_sig_type;

  typedef struct packed
  {
    logic start;
    logic step_end;
    logic file_end;
    logic [7:0] verdict;
    logic hv_on;
    logic malfunction;
  } trh_seq_type;

  typedef struct packed
  {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } trh_bus_type;
endpackage : trh_pkg

/* File: hdl/trh_outputs.sv */
`timescale 1ns/1ps
`default_nettype none
`include "trh_cfg.svh"
module trh_outputs
  import trh_pkg::*;
#(
  parameter int unsigned PULSE_CYC = `TRH_PULSE_CYC,
  parameter int unsigned CNT_W = 26
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire trh_bus_type bus,
  output logic [`TRH_DATA_W-1:0] rdata,
  input wire trh_seq_type seq,
  output logic [`TRH_NUM_PINS-1:0] hnd_out,
  output logic irq
);

  // Refused at elaboration so a bad count never reaches silicon
  if (PULSE_CYC < 1 || PULSE_CYC >= (64'h1 << CNT_W))
  begin : g_bad_pulse
    $error("PULSE_CYC does not fit the pulse counter");
  end

  localparam logic [CNT_W-1:0] PULSE_LEN = CNT_W'(PULSE_CYC);

  // Configuration registers
  logic step_gran_ff;
  logic nxt_step_gran;
  logic [`TRH_DATA_W-1:0] mode_ff;
  logic [`TRH_DATA_W-1:0] nxt_mode;
  logic [`TRH_NUM_EV-1:0] irq_mask_ff;
  logic [`TRH_NUM_EV-1:0] nxt_irq_mask;

  always_comb
  begin
    nxt_step_gran = step_gran_ff;
    nxt_mode = mode_ff;
    nxt_irq_mask = irq_mask_ff;
    if (bus.wr)
    begin
      if (bus.addr == `TRH_OFS_CTRL)
        nxt_step_gran = bus.wdata[0];
      else if (bus.addr == `TRH_OFS_MODE)
        nxt_mode = bus.wdata; // RQ14
      else if (bus.addr == `TRH_OFS_IRQ_MASK)
        nxt_irq_mask = bus.wdata[`TRH_NUM_EV-1:0];
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      step_gran_ff <= `TRH_RST_CTRL;
      mode_ff <= `TRH_RST_MODE;
      irq_mask_ff <= `TRH_RST_MASK;
    end
    else
    begin
      step_gran_ff <= nxt_step_gran;
      mode_ff <= nxt_mode;
      irq_mask_ff <= nxt_irq_mask;
    end
  end

  // Test sequence state and latched verdicts
  logic busy_ff;
  logic nxt_busy;
  logic done_ff;
  logic nxt_done;
  logic [`TRH_NUM_UNITS-1:0] acc_ff;
  logic [`TRH_NUM_UNITS-1:0] nxt_acc;
  logic [`TRH_NUM_UNITS-1:0] res_ff;
  logic [`TRH_NUM_UNITS-1:0] nxt_res;

  always_comb
  begin
    nxt_busy = busy_ff;
    nxt_done = done_ff;
    nxt_acc = acc_ff;
    nxt_res = res_ff;
    if (seq.start)
    begin
      // Old verdicts are withdrawn so a new run never shows stale passes
      nxt_busy = 1'b1; // RQ8
      nxt_done = 1'b0;
      nxt_acc = '1;
      nxt_res = '0;
    end
    else if (busy_ff)
    begin
      if (seq.step_end)
      begin
        nxt_acc = acc_ff & seq.verdict;
        if (step_gran_ff)
        begin
          nxt_res = seq.verdict; // RQ13
          nxt_done = 1'b1;
        end
      end
      if (seq.file_end)
      begin
        nxt_busy = 1'b0; // RQ8
        nxt_done = 1'b1;
        if (!step_gran_ff)
          nxt_res = seq.step_end ? (acc_ff & seq.verdict) : acc_ff; // RQ13
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      acc_ff <= '1;
      res_ff <= '0;
    end
    else
    begin
      busy_ff <= nxt_busy;
      done_ff <= nxt_done;
      acc_ff <= nxt_acc;
      res_ff <= nxt_res;
    end
  end

  // Logical (active-true) condition of every handler pin
  logic [`TRH_NUM_PINS-1:0] cond;

  always_comb
  begin
    cond = '0;
    cond[`TRH_NUM_UNITS-1:0] = done_ff ? res_ff : '0; // RQ3
    cond[`TRH_PIN_PASS] = done_ff & (&res_ff); // RQ4
    cond[`TRH_PIN_FAIL] = done_ff & ~(|res_ff); // RQ5
    cond[`TRH_PIN_SPARE] = 1'b0; // RQ15
    cond[`TRH_PIN_WAIT] = busy_ff & ~seq.hv_on; // RQ6
    cond[`TRH_PIN_READY] = ~busy_ff; // RQ7
    cond[`TRH_PIN_TEST] = busy_ff; // RQ8
    cond[`TRH_PIN_HV] = seq.hv_on; // RQ9
    cond[`TRH_PIN_FAULT] = seq.malfunction; // RQ10
  end

  // Per-pin signal shaping, one pulse counter per pin
  // Per-pin flops gathered on nets so every bit keeps a single driver
  wire logic [`TRH_NUM_PINS-1:0] cond_q_ff;
  wire logic [`TRH_NUM_PINS-1:0] hnd_out_ff;

  genvar k;
  generate
    for (k = 0; k < `TRH_NUM_PINS; k++)
    begin : g_pin
      trh_sig_type sig;
      logic [CNT_W-1:0] cnt_ff;
      logic [CNT_W-1:0] nxt_cnt;
      logic nxt_out;
      logic rise;
      logic q_ff;
      logic out_ff;
      assign cond_q_ff[k] = q_ff;
      assign hnd_out_ff[k] = out_ff;
      assign sig = trh_sig_type'(mode_ff[2*k+1:2*k]);
      assign rise = cond[k] & ~cond_q_ff[k];

      always_comb
      begin
        nxt_cnt = cnt_ff;
        if (rise)
          nxt_cnt = PULSE_LEN; // RQ14
        else if (cnt_ff != '0)
          nxt_cnt = cnt_ff - 1'b1;
        case (sig)
          active_high_level: nxt_out = cond[k]; // RQ11
          active_low_level: nxt_out = ~cond[k]; // RQ12
          positive_pulse: nxt_out = (nxt_cnt != '0); // RQ1
          default: nxt_out = (nxt_cnt == '0); // RQ2
        endcase
      end

      always_ff @(posedge sys_clk or posedge rst)
      begin
        if (rst)
        begin
          cnt_ff <= '0;
          q_ff <= 1'b0;
          out_ff <= 1'b0;
        end
        else
        begin
          cnt_ff <= nxt_cnt;
          q_ff <= cond[k];
          out_ff <= nxt_out;
        end
      end
    end
  endgenerate

  assign hnd_out = hnd_out_ff;

  // Sticky events, write one to clear; a new event beats a clear
  logic [`TRH_NUM_EV-1:0] ev;
  logic [`TRH_NUM_EV-1:0] irq_stat_ff;
  logic [`TRH_NUM_EV-1:0] nxt_irq_stat;
  logic irq_ff;
  logic nxt_irq;

  always_comb
  begin
    ev = '0;
    ev[`TRH_EV_START] = seq.start;
    ev[`TRH_EV_FILE_END] = busy_ff & seq.file_end;
    ev[`TRH_EV_FAULT] = cond[`TRH_PIN_FAULT] & ~cond_q_ff[`TRH_PIN_FAULT];
    ev[`TRH_EV_STEP_END] = busy_ff & seq.step_end;
    nxt_irq_stat = irq_stat_ff;
    if (bus.wr && bus.addr == `TRH_OFS_IRQ_STAT)
      nxt_irq_stat = irq_stat_ff & ~bus.wdata[`TRH_NUM_EV-1:0];
    nxt_irq_stat = nxt_irq_stat | ev;
    nxt_irq = |(nxt_irq_stat & nxt_irq_mask);
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      irq_stat_ff <= '0;
      irq_ff <= 1'b0;
    end
    else
    begin
      irq_stat_ff <= nxt_irq_stat;
      irq_ff <= nxt_irq;
    end
  end

  assign irq = irq_ff;

  // Read port: data valid the cycle after the strobe, zero otherwise
  logic [`TRH_DATA_W-1:0] rdata_ff;
  logic [`TRH_DATA_W-1:0] nxt_rdata;

  always_comb
  begin
    nxt_rdata = '0;
    if (bus.rd)
    begin
      if (bus.addr == `TRH_OFS_CTRL)
        nxt_rdata[0] = step_gran_ff;
      else if (bus.addr == `TRH_OFS_MODE)
        nxt_rdata = mode_ff;
      else if (bus.addr == `TRH_OFS_STAT)
        nxt_rdata = {6'h00, done_ff, busy_ff, res_ff, hnd_out_ff};
      else if (bus.addr == `TRH_OFS_IRQ_STAT)
        nxt_rdata[`TRH_NUM_EV-1:0] = irq_stat_ff;
      else if (bus.addr == `TRH_OFS_IRQ_MASK)
        nxt_rdata[`TRH_NUM_EV-1:0] = irq_mask_ff;
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      rdata_ff <= '0;
    else
      rdata_ff <= nxt_rdata;
  end

  assign rdata = rdata_ff;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  AST_POS_PULSE: assert property ( // RQ1
    g_pin[`TRH_PIN_FAULT].rise
    && g_pin[`TRH_PIN_FAULT].sig == positive_pulse
    |=> hnd_out_ff[`TRH_PIN_FAULT] [*8])
    else $error("positive pulse too short");

  AST_NEG_PULSE: assert property ( // RQ2
    g_pin[`TRH_PIN_TEST].rise
    && g_pin[`TRH_PIN_TEST].sig == negative_pulse
    |=> !hnd_out_ff[`TRH_PIN_TEST] [*8])
    else $error("negative pulse too short");

  AST_UNIT_PASS: assert property ( // RQ3
    busy_ff && step_gran_ff && seq.step_end && seq.verdict[0]
    && !seq.start |=> cond[0])
    else $error("unit pass not shown");

  AST_ALL_PASS: assert property ( // RQ4
    busy_ff && step_gran_ff && seq.step_end && seq.verdict == '1
    && !seq.start |=> cond[`TRH_PIN_PASS])
    else $error("overall pass missing");

  AST_ALL_FAIL: assert property ( // RQ5
    busy_ff && step_gran_ff && seq.step_end && seq.verdict == '0
    && !seq.start |=> cond[`TRH_PIN_FAIL])
    else $error("overall fail missing");

  AST_WAIT: assert property ( // RQ6
    seq.start && !seq.hv_on ##1 !seq.hv_on && !seq.start
    |-> cond[`TRH_PIN_WAIT])
    else $error("wait missing without voltage");

  AST_READY: assert property ( // RQ7
    busy_ff && g_pin[`TRH_PIN_READY].sig == active_high_level
    |=> !hnd_out_ff[`TRH_PIN_READY])
    else $error("ready shown while testing");

  AST_BUSY: assert property ( // RQ8
    seq.start |=> busy_ff ##1 (busy_ff || $past(seq.file_end)))
    else $error("test flag not held");

  AST_READY_LOW: assert property ( // RQ12
    !busy_ff && g_pin[`TRH_PIN_READY].sig == active_low_level
    |=> !hnd_out_ff[`TRH_PIN_READY])
    else $error("ready low level wrong");

  AST_SPARE: assert property ( // RQ15
    $past(mode_ff[2*`TRH_PIN_SPARE]) == 1'b0
    |-> !hnd_out_ff[`TRH_PIN_SPARE])
    else $error("spare left inactive level");

endmodule : trh_outputs
`default_nettype wire

/* File: testbench/trh_handler_model.sv */
`timescale 1ns/1ps
`default_nettype none
module trh_handler_model
(
  input wire logic sys_clk,
  input wire logic [15:0] pins,
  output logic [15:0] hi_len [16],
  output logic [15:0] lo_len [16]
);
  logic [15:0] hi_run [16] = '{default: 16'h0};
  logic [15:0] lo_run [16] = '{default: 16'h0};
  // Handler side only samples; a run length is kept once the pin flips
  always_ff @(posedge sys_clk)
  begin
    for (int k = 0; k < 16; k++)
    begin
      if (pins[k])
      begin
        hi_run[k] <= hi_run[k] + 16'h1;
        lo_run[k] <= 16'h0;
        if (lo_run[k] != 16'h0)
          lo_len[k] <= lo_run[k];
      end
      else
      begin
        lo_run[k] <= lo_run[k] + 16'h1;
        hi_run[k] <= 16'h0;
        if (hi_run[k] != 16'h0)
          hi_len[k] <= hi_run[k];
      end
    end
  end
endmodule : trh_handler_model
`default_nettype wire

/* File: testbench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "trh_cfg.svh"
`define CHK(a, b) \
  begin \
    cmp_count++; \
    if ((a) !== (b)) \
    begin \
      err_total++; \
      $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); \
    end \
  end
module testbench
  import trh_pkg::*;
;
  localparam int unsigned PULSE = 20;
  logic sys_clk;
  logic rst;
  trh_bus_type bus;
  trh_seq_type seq;
  logic [31:0] rdata;
  logic [15:0] pins;
  logic irq;
  logic [15:0] hi_len [16];
  logic [15:0] lo_len [16];
  logic [31:0] d;
  int err_total = 0;
  int cmp_count = 0;

  // Short pulse keeps the run brief; asserts need at least 8
  trh_outputs #(.PULSE_CYC(PULSE)) dut (.sys_clk(sys_clk), .rst(rst),
    .bus(bus), .rdata(rdata), .seq(seq), .hnd_out(pins), .irq(irq));
  trh_handler_model hm (.sys_clk(sys_clk), .pins(pins),
    .hi_len(hi_len), .lo_len(lo_len));

  always #2.5 sys_clk = ~sys_clk;

  task give_verdict;
    if (err_total == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict

  task cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc

  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    bus.addr <= a;
    bus.wdata <= v;
    bus.wr <= 1'b1;
    @(posedge sys_clk);
    bus.wr <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge sys_clk);
    bus.rd <= 1'b0;
    #1;
    v = rdata;
  endtask : rd

  // e: bit0 start, bit1 step end, bit2 file end
  task fire(input logic [2:0] e, input logic [7:0] v);
    @(posedge sys_clk);
    seq.start <= e[0];
    seq.step_end <= e[1];
    seq.file_end <= e[2];
    seq.verdict <= v;
    @(posedge sys_clk);
    seq.start <= 1'b0;
    seq.step_end <= 1'b0;
    seq.file_end <= 1'b0;
    cyc(3);
  endtask : fire

  task wait_pin(input int k, input logic lvl);
    int n;
    n = 0;
    while (pins[k] !== lvl && n < 200)
    begin
      cyc(1);
      n++;
    end
    if (n == 200)
    begin
      err_total++;
      give_verdict();
    end
  endtask : wait_pin

  task t_regs;
    rd(`TRH_OFS_MODE, d);
    `CHK(d, `TRH_RST_MODE);
    wr(8'h14, 32'hffff_ffff);
    rd(8'h14, d);
    `CHK(d, 32'h0);
    cyc(1);
    `CHK(rdata, 32'h0);
  endtask : t_regs

  task t_step;
    wr(`TRH_OFS_CTRL, 32'h1);
    wr(`TRH_OFS_IRQ_MASK, 32'hf);
    fire(3'h1, 8'h00);
    `CHK(pins[15:11], 5'b00101);
    @(posedge sys_clk);
    seq.hv_on <= 1'b1;
    cyc(3);
    `CHK(pins[15:11], 5'b01100);
    fire(3'h2, 8'hff);
    `CHK(pins[9:0], 10'h1ff);
    fire(3'h2, 8'h00);
    `CHK(pins[9:0], 10'h200);
    @(posedge sys_clk);
    seq.hv_on <= 1'b0;
    fire(3'h4, 8'h00);
    `CHK(pins[13:12], 2'b01);
    `CHK(irq, 1'b1);
    rd(`TRH_OFS_IRQ_STAT, d);
    `CHK(d[3:0], 4'hb);
    wr(`TRH_OFS_IRQ_STAT, 32'hb);
    cyc(2);
    `CHK(irq, 1'b0);
  endtask : t_step

  task t_file;
    wr(`TRH_OFS_CTRL, 32'h0);
    fire(3'h1, 8'h00);
    fire(3'h2, 8'hff);
    `CHK(pins[7:0], 8'h00);
    fire(3'h2, 8'hfe);
    fire(3'h4, 8'h00);
    `CHK(pins[9:0], 10'h0fe);
  endtask : t_file

  // Fault as positive pulse, test as negative pulse, ready and spare low
  task t_pulse;
    wr(`TRH_OFS_MODE, 32'h8d10_0000);
    cyc(3);
    `CHK(pins[13:10], 4'b1001);
    `CHK(pins[15], 1'b0);
    @(posedge sys_clk);
    seq.malfunction <= 1'b1;
    cyc(5);
    `CHK(pins[15], 1'b1);
    fire(3'h1, 8'h00);
    wait_pin(15, 1'b0);
    // The model latches a run length one edge after the pin flips
    cyc(1);
    `CHK(hi_len[15], 16'(PULSE));
    wait_pin(13, 1'b1);
    cyc(1);
    `CHK(lo_len[13], 16'(PULSE));
    `CHK(pins[10], 1'b1);
    @(posedge sys_clk);
    seq.malfunction <= 1'b0;
    fire(3'h4, 8'h00);
  endtask : t_pulse

  initial
  begin
    sys_clk = 1'b0;
    rst = 1'b1;
    bus = '0;
    seq = '0;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    cyc(2);
    `CHK(pins, 16'h1000);
    t_regs();
    t_step();
    t_file();
    t_pulse();
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
